// *** pkg/lars_defs.svh ***
`ifndef LARS_DEFS_SVH
`define LARS_DEFS_SVH
// Pixels per section and in a serial chain
`define LARS_SEC_PIXELS 640
`define LARS_CHAIN_PIXELS 1280
// Stage index width (0..640 plus tail)
`define LARS_CNT_W 11
// Integrator reset length in pixel clocks
`define LARS_RESET_CLKS 18
// Charge transfer time in ns, and the 250 MHz clock period in ns
`define LARS_TQT_NS 20000
`define LARS_CLK_NS 4
`define LARS_TQT_CYC ((`LARS_TQT_NS + `LARS_CLK_NS - 1) / `LARS_CLK_NS)
// Pixel clock half period in system clocks
`define LARS_HALF_CYC 4
// Pixel sample width
`define LARS_PIX_W 12
`endif

// *** pkg/lars_pkg.sv ***
`include "lars_defs.svh"
package lars_pkg;
  // Controller sequencing states
  typedef enum logic [2:0] {
    LARS_IDLE,
    LARS_START,
    LARS_SHIFT,
    LARS_TAIL,
    LARS_WAIT
  } lars_state_t;
  typedef logic [`LARS_PIX_W-1:0] lars_pix_t;
endpackage : lars_pkg

// *** pkg/lars_if.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lars_defs.svh"
interface lars_if;
  logic [1:0] start_in;        // start_in_sec1/2
  logic [1:0] sample_latch;    // sample_latch_sec1/2
  logic [1:0] pixel_clock;     // pixel_clock_sec1/2, as level inputs
  logic [1:0] carry_out;       // carry_out_sec1/2
  logic [1:0] analog_oe;       // analog_out_sec1/2 driven
  logic [`LARS_PIX_W-1:0] analog_out_sec1;
  logic [`LARS_PIX_W-1:0] analog_out_sec2;
  modport device (
    input start_in, sample_latch, pixel_clock,
    output carry_out, analog_oe, analog_out_sec1, analog_out_sec2
  );
  modport ctrl (
    output start_in, sample_latch, pixel_clock,
    input carry_out, analog_oe, analog_out_sec1, analog_out_sec2
  );
endinterface : lars_if
`default_nettype wire

// *** logic/lars_sensor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lars_defs.svh"
module lars_sensor
  import lars_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire lars_pix_t pixel_sec1_i,
  input wire lars_pix_t pixel_sec2_i,
  output logic [1:0] pixel_index_valid_o,
  output logic [1:0] reset_active_o,
  lars_if.device link
);
  // ****************************************
  // Per-section sequencer
  // ****************************************
  logic [1:0] clk_d_reg;
  logic [1:0] latch_d_reg;
  logic [1:0] rise;
  lars_pix_t pix [2];
  lars_pix_t aout_reg [2];
  assign pix[0] = pixel_sec1_i;
  assign pix[1] = pixel_sec2_i;
  assign link.analog_out_sec1 = aout_reg[0];
  assign link.analog_out_sec2 = aout_reg[1];

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_sec
      logic [`LARS_CNT_W-1:0] stage_reg; // 0 idle, k = token at stage k
      logic [4:0] rst_cnt_reg;
      assign rise[s] = link.pixel_clock[s] & ~clk_d_reg[s];
      // Edge history of the section clock and hold input
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          clk_d_reg[s] <= 1'b0;
          latch_d_reg[s] <= 1'b0;
        end else if (ce_i) begin
          clk_d_reg[s] <= link.pixel_clock[s];
          latch_d_reg[s] <= link.sample_latch[s];
        end
      end
      // Token shifts one stage per pixel clock rise; start capture loads stage 1
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage_reg <= '0;
        end else if (ce_i && rise[s]) begin
          if (link.start_in[s]) begin
            stage_reg <= `LARS_CNT_W'(1);
          end else if (stage_reg != '0 && stage_reg <= `LARS_CNT_W'(`LARS_SEC_PIXELS)) begin
            stage_reg <= stage_reg + `LARS_CNT_W'(1);
          end else begin
            stage_reg <= '0;
          end
        end
      end
      // Hold rise starts integrator reset; it ends on the 18th clock rise, counting the start capture rise
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rst_cnt_reg <= '0;
        end else if (ce_i) begin
          if (link.sample_latch[s] && !latch_d_reg[s]) begin
            rst_cnt_reg <= 5'(`LARS_RESET_CLKS);
          end else if (rise[s] && rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
          end
        end
      end
      assign reset_active_o[s] = rst_cnt_reg != '0;
      // Stored charge steps out on every pixel clock rise; driven only while token is inside the register
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          aout_reg[s] <= '0;
        end else if (ce_i && rise[s]) begin
          aout_reg[s] <= pix[s];
        end
      end
      assign pixel_index_valid_o[s] = stage_reg != '0 &&
        stage_reg <= `LARS_CNT_W'(`LARS_SEC_PIXELS);
      assign link.analog_oe[s] = pixel_index_valid_o[s];
      // Carry high on 640th rise, low on 641st; feeds next section or end mark
      assign link.carry_out[s] = stage_reg == `LARS_CNT_W'(`LARS_SEC_PIXELS);
    end
  endgenerate
endmodule : lars_sensor
`default_nettype wire

// *** logic/lars_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lars_defs.svh"
// Contract
// - Each section shifts 640 stages, one per clock
// - Controller starts cycle with captured start one
// - Hold rise disconnects capacitors, starts reset
// - Each clock steps one pixel to output
// - Integrator reset ends eighteen clocks after start
// - Section one carry rises on 640th edge
// - 641st edge drops carry, output goes idle
// - Serial mode: section two carry at 1280
// - Controller issues 1281st clock to finish
// - Next start waits transfer time after 1281
// - Support parallel and serial section operation
// - Serial: carry one feeds section two start
// - Hold tied per mode as wired
// - Section two carry marks end of data
// - Output idle outside output phase
// - Section clock governs transfer, output, reset
// - Transfer time taken as 20 microseconds
// - Start drops before next clock edge
// - Minimum integration counts eighteen setup clocks
module lars_ctrl
  import lars_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic serial_mode_i,
  input wire logic frame_req_i,
  output logic busy_o,
  output logic frame_done_o,
  output lars_pix_t pix_data_o,
  output logic pix_sec_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  lars_if.ctrl link
);
  // ****************************************
  // Pixel clock generator
  // ****************************************
  lars_state_t state_reg;
  logic [2:0] half_reg;
  logic pclk_reg;
  logic start_reg;
  logic [`LARS_CNT_W-1:0] edge_reg;
  logic [15:0] wait_reg;
  logic stall;
  logic in_ready;
  logic run;
  logic rise_now;
  assign run = state_reg == LARS_START || state_reg == LARS_SHIFT || state_reg == LARS_TAIL;
  // Buffer back-pressure freezes the pixel clock so no sample is lost
  assign stall = !in_ready;
  assign rise_now = run && !stall && !pclk_reg && half_reg == 3'(`LARS_HALF_CYC - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_reg <= '0;
      pclk_reg <= 1'b0;
    end else if (ce_i && run && !stall) begin
      if (half_reg == 3'(`LARS_HALF_CYC - 1)) begin
        half_reg <= '0;
        pclk_reg <= !pclk_reg;
      end else begin
        half_reg <= half_reg + 3'h1;
      end
    end else if (ce_i && !run) begin
      half_reg <= '0;
      pclk_reg <= 1'b0;
    end
  end

  // ****************************************
  // Frame sequencer
  // ****************************************
  // Start stays high over exactly one rising edge, dropped right after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= LARS_IDLE;
      start_reg <= 1'b0;
      edge_reg <= '0;
      wait_reg <= '0;
    end else if (ce_i) begin
      case (state_reg)
        LARS_IDLE: begin
          if (frame_req_i) begin
            start_reg <= 1'b1;
            edge_reg <= '0;
            state_reg <= LARS_START;
          end
        end
        LARS_START: begin
          if (rise_now) begin
            state_reg <= LARS_SHIFT;
            edge_reg <= `LARS_CNT_W'(1);
          end
        end
        LARS_SHIFT: begin
          start_reg <= 1'b0;
          if (rise_now) begin
            edge_reg <= edge_reg + `LARS_CNT_W'(1);
            // Last edge is 641 parallel, 1281 serial
            if (edge_reg == (serial_mode_i ? `LARS_CNT_W'(`LARS_CHAIN_PIXELS)
                                           : `LARS_CNT_W'(`LARS_SEC_PIXELS))) begin
              state_reg <= LARS_TAIL;
            end
          end
        end
        LARS_TAIL: begin
          if (pclk_reg == 1'b0 && half_reg == '0) begin
            wait_reg <= 16'(`LARS_TQT_CYC);
            state_reg <= LARS_WAIT;
          end
        end
        LARS_WAIT: begin
          if (wait_reg == 16'h0001 || wait_reg == '0) begin
            state_reg <= LARS_IDLE;
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        default: state_reg <= LARS_IDLE;
      endcase
    end
  end
  assign busy_o = state_reg != LARS_IDLE;
  assign frame_done_o = ce_i && state_reg == LARS_WAIT && wait_reg <= 16'h0001;

  // Serial chains carry one into section two start; hold wiring per mode
  assign link.pixel_clock = {pclk_reg, pclk_reg};
  assign link.start_in[0] = start_reg;
  assign link.start_in[1] = serial_mode_i ? link.carry_out[0] : start_reg;
  assign link.sample_latch[0] = start_reg;
  assign link.sample_latch[1] = serial_mode_i ? start_reg : link.start_in[1];

  // ****************************************
  // Two-entry pixel buffer
  // ****************************************
  // Sample two clocks after the pixel clock rises: one for the pin, one for the sensor register
  logic [1:0] cap;
  logic [1:0] push_cnt;
  lars_pix_t buf_d_reg [2];
  logic buf_s_reg [2];
  logic [1:0] cnt_reg;
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic push;
  logic pop;
  logic [1:0] pend_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= '0;
    end else if (ce_i) begin
      pend_reg <= {pend_reg[0], rise_now};
    end
  end
  assign cap = {2{pend_reg[1]}} & link.analog_oe;
  assign in_ready = cnt_reg == '0;
  assign push = ce_i && in_ready && cap != '0;
  assign push_cnt = !push ? 2'h0 : ((cap == 2'b11) ? 2'h2 : 2'h1);
  assign pop = ce_i && pix_valid_o && pix_ready_i;
  assign pix_valid_o = cnt_reg != '0;
  assign pix_data_o = buf_d_reg[rd_ptr_reg];
  assign pix_sec_o = buf_s_reg[rd_ptr_reg];
  // Clock only advances when empty, so a push always finds room
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      buf_d_reg[0] <= '0;
      buf_d_reg[1] <= '0;
      buf_s_reg[0] <= 1'b0;
      buf_s_reg[1] <= 1'b0;
    end else begin
      if (push) begin
        if (cap == 2'b11) begin
          // Parallel mode: both sections land at once, section one first in line
          buf_d_reg[wr_ptr_reg] <= link.analog_out_sec1;
          buf_s_reg[wr_ptr_reg] <= 1'b0;
          buf_d_reg[!wr_ptr_reg] <= link.analog_out_sec2;
          buf_s_reg[!wr_ptr_reg] <= 1'b1;
        end else begin
          buf_d_reg[wr_ptr_reg] <= cap[1] ? link.analog_out_sec2 : link.analog_out_sec1;
          buf_s_reg[wr_ptr_reg] <= cap[1];
          wr_ptr_reg <= !wr_ptr_reg;
        end
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + push_cnt - 2'(pop ? 1 : 0);
    end
  end
endmodule : lars_ctrl
`default_nettype wire

// *** dv/lars_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lars_defs.svh"
// ****************************
// Link checker
// ****************************
module lars_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] start_in,
  input wire logic [1:0] sample_latch,
  input wire logic [1:0] pixel_clock,
  input wire logic [1:0] carry_out,
  input wire logic [1:0] analog_oe
);
  localparam int CHARGE_TRANSFER_TIME = `LARS_TQT_CYC;
  logic [1:0] lst_reg;
  logic [1:0] rise;
  logic [10:0] cnt_reg [2];
  logic [12:0] gap_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Rises exactly as the sensor detects them
  assign rise = pixel_clock & ~lst_reg;
  always_ff @(posedge clk_i) begin
    lst_reg <= pixel_clock;
  end
  // Expected stage per section; 641 is the closing rise, then idle
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < 2; s++) begin
      if (rst_i)
        cnt_reg[s] <= 11'h000;
      else if (rise[s] && start_in[s])
        cnt_reg[s] <= 11'h001;
      else if (rise[s] && cnt_reg[s] != 11'h000)
        cnt_reg[s] <= (cnt_reg[s] == 11'h281) ? 11'h000 : cnt_reg[s] + 11'h001;
    end
  end
  // Idle cycles since any output was driven; saturates so reset never looks like a short gap
  always_ff @(posedge clk_i) begin
    if (rst_i)
      gap_reg <= 13'h1FFF;
    else if (|analog_oe)
      gap_reg <= 13'h0000;
    else if (gap_reg != 13'h1FFF)
      gap_reg <= gap_reg + 13'h0001;
  end
  property p_c1;
    carry_out[0] == (cnt_reg[0] == 11'h280);
  endproperty
  a_c1: assert property (p_c1) else $error("carry one off its stage");
  property p_c2;
    carry_out[1] == (cnt_reg[1] == 11'h280);
  endproperty
  a_c2: assert property (p_c2) else $error("carry two off its stage");
  property p_oe1;
    analog_oe[0] == (cnt_reg[0] != 11'h000 && cnt_reg[0] != 11'h281);
  endproperty
  a_oe1: assert property (p_oe1) else $error("output one drive wrong");
  property p_oe2;
    analog_oe[1] == (cnt_reg[1] != 11'h000 && cnt_reg[1] != 11'h281);
  endproperty
  a_oe2: assert property (p_oe2) else $error("output two drive wrong");
  property p_drop;
    rise[0] && carry_out[0] |=> !carry_out[0] && !analog_oe[0];
  endproperty
  a_drop: assert property (p_drop) else $error("carry one not closed");
  property p_sdrop;
    rise[0] && start_in[0] |-> ##[1:7] !start_in[0];
  endproperty
  a_sdrop: assert property (p_sdrop) else $error("start held too long");
  property p_hold;
    sample_latch[0] == start_in[0];
  endproperty
  a_hold: assert property (p_hold) else $error("hold not tied to start");
  property p_gap;
    $rose(start_in[0]) |-> gap_reg > CHARGE_TRANSFER_TIME - 8;
  endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  c_serial: cover property (rise[1] && carry_out[1]);
  c_close: cover property ($fell(analog_oe[0]));
  c_both: cover property (rise[0] && start_in[0] && start_in[1]);
endmodule : lars_asserts
`default_nettype wire

// *** dv/test_linear_array_readout_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************
// Bench
// ****************************
module test_linear_array_readout_sequencer;
  import lars_pkg::*;
  typedef struct packed {logic serial; logic [4:0] rdiv;} lars_row_t;
  localparam int LIMIT = 95000;
  localparam lars_row_t ROWS [3] = '{'{1'b1, 5'h01}, '{1'b0, 5'h01}, '{1'b1, 5'h08}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic serial_mode = 1'b0;
  logic frame_req = 1'b0;
  logic pix_ready = 1'b0;
  lars_pix_t pix1 = 12'h000;
  lars_pix_t pix2 = 12'h000;
  logic [4:0] rdiv = 5'h01;
  logic busy, done, psec, pvalid;
  lars_pix_t pdata;
  logic [1:0] ract;
  logic [1:0] lpc = 2'b00;
  logic [10:0] tc [2];
  logic [11:0] rcnt = 12'h000;
  int nxt [2];
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  lars_if link();
  lars_sensor i_lars_sensor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pixel_sec1_i(pix1),
    .pixel_sec2_i(pix2), .pixel_index_valid_o(), .reset_active_o(ract), .link(link));
  lars_ctrl i_lars_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .serial_mode_i(serial_mode),
    .frame_req_i(frame_req), .busy_o(busy), .frame_done_o(done), .pix_data_o(pdata),
    .pix_sec_o(psec), .pix_valid_o(pvalid), .pix_ready_i(pix_ready), .link(link));
  lars_asserts i_lars_asserts (.clk_i(clk_i), .rst_i(rst_i), .start_in(link.start_in),
    .sample_latch(link.sample_latch), .pixel_clock(link.pixel_clock),
    .carry_out(link.carry_out), .analog_oe(link.analog_oe));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // One frame: request, then wait for the end of the transfer wait
  task automatic run_frame(input lars_row_t r);
    int n;
    @(posedge clk_i);
    #1;
    serial_mode = r.serial;
    rdiv = r.rdiv;
    nxt = '{1, 1};
    rcnt = 12'h000;
    frame_req = 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (busy !== 1'b1 && n < 100);
    frame_req = 1'b0;
    do begin
      @(posedge clk_i);
      #1;
    end while (done !== 1'b1);
    check(nxt[0][11:0], 12'h281);
    check(nxt[1][11:0], 12'h281);
    check(rcnt, 12'h012);
  endtask : run_frame
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Timeout, stage tracking and stream scoring; a pixel's value is its section bit above its own stage number
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      stop_test();
    end
    lpc <= link.pixel_clock;
    for (int s = 0; s < 2; s++) begin
      if (link.pixel_clock[s] && !lpc[s])
        tc[s] <= link.start_in[s] ? 11'h001 : tc[s] + 11'h001;
    end
    if (link.pixel_clock[0] && !lpc[0] && ract[0] === 1'b1)
      rcnt <= rcnt + 12'h001;
    if (!rst_i && pvalid === 1'b1 && pix_ready === 1'b1) begin
      check(pdata, {psec, nxt[psec][10:0]});
      if (serial_mode)
        check({11'h000, psec}, {11'h000, nxt[0] > 640});
      nxt[psec]++;
    end
  end
  // Inputs change a fixed delay after the edge; ready stalls per row
  always @(posedge clk_i) begin
    #1;
    // Present the value of the stage the next rise will reach
    pix1 <= {1'b0, link.start_in[0] ? 11'h001 : tc[0] + 11'h001};
    pix2 <= {1'b1, link.start_in[1] ? 11'h001 : tc[1] + 11'h001};
    pix_ready <= (cyc % rdiv == 0);
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    foreach (ROWS[i]) run_frame(ROWS[i]);
    // Reset in mid-frame must leave the link idle
    serial_mode = 1'b1;
    nxt = '{1, 1};
    frame_req = 1'b1;
    repeat (400) @(posedge clk_i);
    #1 rst_i = 1'b1;
    frame_req = 1'b0;
    @(posedge clk_i);
    #1 rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    check({8'h00, link.carry_out, link.analog_oe}, 12'h000);
    check({11'h000, busy}, 12'h000);
    run_frame(ROWS[0]);
    stop_test();
  end
endmodule : test_linear_array_readout_sequencer
`default_nettype wire
